// >>> design/ebm_pkg.sv
package ebm_pkg;

    // ------------------------------------------------------------
    // Bus sizes
    // ------------------------------------------------------------
    localparam int DATA_W = 32;
    localparam int ADDR_W = 26;
    localparam int TIME_W = 6;
    localparam int CNT_W  = 8;

    // ------------------------------------------------------------
    // Memory areas, selected by transfer address bits 31:28
    // ------------------------------------------------------------
    localparam logic [3:0] AREA_LSB_POS = 4'h0;
    localparam int         AREA_MSB     = 31;
    localparam int         AREA_LSB     = 28;
    localparam logic [3:0] AREA_CS0     = 4'h1;
    localparam logic [3:0] AREA_CS3     = 4'h4;
    localparam logic [3:0] AREA_CS4     = 4'h5;
    localparam logic [3:0] AREA_CS5     = 4'h6;
    localparam logic [3:0] AREA_CS7     = 4'h8;

    // ------------------------------------------------------------
    // Card mode select field position
    // ------------------------------------------------------------
    localparam int MODE_MSB = 23;
    localparam int MODE_LSB = 21;

    // ------------------------------------------------------------
    // Device width codes
    // ------------------------------------------------------------
    localparam logic [1:0] WIDTH_8  = 2'h0;
    localparam logic [1:0] WIDTH_16 = 2'h1;
    localparam logic [1:0] WIDTH_32 = 2'h2;

    // ------------------------------------------------------------
    // Values after reset
    // ------------------------------------------------------------
    localparam logic             PULLUP_RST = 1'b1;
    localparam logic [CNT_W-1:0] CNT_RST    = 8'h00;
    localparam logic [7:0]       CS_N_RST   = 8'hff;

    // Card access modes
    typedef enum logic [1:0] {
        EBM_CARD_ATTR,
        EBM_CARD_COMMON,
        EBM_CARD_IO,
        EBM_CARD_IDE
    } ebm_card_mode_t;

endpackage

// >>> design/ebm_phase_if.sv
`timescale 1ns/10ps
interface ebm_phase_if;

    logic                      busy;
    logic [ebm_pkg::CNT_W-1:0] cnt;
    logic [ebm_pkg::TIME_W-1:0] setup;
    logic [ebm_pkg::TIME_W-1:0] pulse;
    logic                      strobe_n;

    // Sequencer side
    modport ctl (
        output busy,
        output cnt,
        output setup,
        output pulse,
        input  strobe_n
    );

    // Strobe shaper side
    modport gen (
        input  busy,
        input  cnt,
        input  setup,
        input  pulse,
        output strobe_n
    );

endinterface

// >>> design/ebm_phase.sv
`timescale 1ns/10ps
module ebm_phase (
    // Timing link to the cycle sequencer
    ebm_phase_if.gen ph
);

    logic [ebm_pkg::CNT_W-1:0] rise_at;

    // Strobe is low from setup until setup plus pulse
    always_comb
    begin
        rise_at     = ebm_pkg::CNT_W'({2'h0, ph.setup}) + ebm_pkg::CNT_W'({2'h0, ph.pulse});
        ph.strobe_n = !(ph.busy && (ph.cnt >= ebm_pkg::CNT_W'({2'h0, ph.setup}))
                        && (ph.cnt < rise_at));
    end

endmodule

// >>> design/ebm_top.sv
`timescale 1ns/10ps
// Behaviour
// - Share 32-bit data and 26 address lines, owner chosen by request arbitration.
// - Address and output controls stay stable while no access runs.
// - Handover waits the float time of the controller that last drove.
// - SDRAM ownership delays static accesses until sdr_req drops and the float time ends.
// - Low data-line pull-ups are on after reset.
// - Pull-up disable bit turns off pull-ups on data lines 0 to 15.
// - Card glue active on chip selects four/five when assigned.
// - Card windows at 0x5000_0000 and 0x6000_0000, 256 MB each.
// - All card modes supported; 16-bit indication and ATA select not handled.
// - Card mode chosen from transfer address bits 23 to 21.
// - Flash glue on chip select three, enabled by its assignment bit.
// - Window 0x4000_0000 to 0x4FFF_FFFF goes to the flash.
// - Chip select three active routes read/write onto flash strobes.
// - Flash strobes drop at once when address leaves that window.
// - Read starts with address; width picks lowest driven address bit.
// - Read strobe: setup from address, pulse low, hold after rise.
// - Chip select follows its own setup, pulse and hold.
// - Cycle equals both strobe sums; the two sums must match.
module ebm_top (
    // Clock and reset
    input  wire  logic                         clock,
    input  wire  logic                         rst_n,
    // Configuration
    input  wire  logic                         data_bus_pullup_disable,
    input  wire  logic                         cs3_flash_assign,
    input  wire  logic                         cs4_card_assign,
    input  wire  logic                         cs5_card_assign,
    input  wire  logic [1:0]                   dev_width,
    input  wire  logic [ebm_pkg::TIME_W-1:0]   read_strobe_setup,
    input  wire  logic [ebm_pkg::TIME_W-1:0]   read_strobe_pulse,
    input  wire  logic [ebm_pkg::TIME_W-1:0]   read_strobe_hold,
    input  wire  logic [ebm_pkg::TIME_W-1:0]   cs_read_setup,
    input  wire  logic [ebm_pkg::TIME_W-1:0]   cs_read_pulse,
    input  wire  logic [ebm_pkg::TIME_W-1:0]   cs_read_hold,
    input  wire  logic [ebm_pkg::TIME_W-1:0]   smc_float_cycles,
    input  wire  logic [ebm_pkg::TIME_W-1:0]   sdr_float_cycles,
    input  wire  logic [15:0]                  card_mode_map,
    // Static memory controller side
    input  wire  logic                         smc_req,
    input  wire  logic                         smc_wr,
    input  wire  logic [31:0]                  smc_addr,
    input  wire  logic [ebm_pkg::DATA_W-1:0]   smc_wdata,
    output logic                               smc_ack,
    output logic [ebm_pkg::DATA_W-1:0]         smc_rdata,
    // SDRAM controller side
    input  wire  logic                         sdr_req,
    input  wire  logic                         sdr_drive,
    input  wire  logic [ebm_pkg::ADDR_W-1:0]   sdr_addr,
    input  wire  logic [ebm_pkg::DATA_W-1:0]   sdr_wdata,
    output logic                               sdr_grant,
    // External memory pins
    output logic [ebm_pkg::ADDR_W-1:0]         mem_addr,
    input  wire  logic [ebm_pkg::DATA_W-1:0]   mem_data_in,
    output logic [ebm_pkg::DATA_W-1:0]         mem_data_out,
    output logic                               mem_data_oe,
    output logic                               read_strobe_n,
    output logic                               write_strobe_n,
    output logic [7:0]                         chip_select_n,
    output logic                               flash_output_enable_n,
    output logic                               flash_write_enable_n,
    output logic                               card_active,
    output logic [1:0]                         card_mode,
    output logic                               pullup_low_en,
    output logic                               cfg_error
);

    typedef enum {
        EBM_IDLE,
        EBM_SMC,
        EBM_SDR,
        EBM_FLOAT
    } ebm_state_t;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    ebm_state_t                   state_reg;
    ebm_state_t                   state_next;
    logic [ebm_pkg::CNT_W-1:0]    cnt_reg;
    logic [ebm_pkg::CNT_W-1:0]    float_reg;
    logic [ebm_pkg::CNT_W-1:0]    cycle_len;
    logic [ebm_pkg::CNT_W-1:0]    cs_len;
    logic [31:0]                  taddr_reg;
    logic                         twr_reg;
    logic                         cycle_end;
    logic                         smc_take;
    logic                         sdr_take;
    logic [ebm_pkg::DATA_W-1:0]   din_meta_reg;
    logic [ebm_pkg::DATA_W-1:0]   din_sync_reg;
    logic [3:0]                   area;
    logic                         in_cs3;
    logic                         in_cs4;
    logic                         in_cs5;
    logic                         strobe_rd_n;
    logic                         strobe_cs_n;
    logic [ebm_pkg::ADDR_W-1:0]   addr_map;

    ebm_phase_if rd_ph ();
    ebm_phase_if cs_ph ();

    // ------------------------------------------------------------
    // Cycle length and configuration check
    // ------------------------------------------------------------

    // Both strobe sums, zero-extended to counter width
    always_comb
    begin
        cycle_len = ebm_pkg::CNT_W'({2'h0, read_strobe_setup})
                  + ebm_pkg::CNT_W'({2'h0, read_strobe_pulse})
                  + ebm_pkg::CNT_W'({2'h0, read_strobe_hold});
        cs_len    = ebm_pkg::CNT_W'({2'h0, cs_read_setup})
                  + ebm_pkg::CNT_W'({2'h0, cs_read_pulse})
                  + ebm_pkg::CNT_W'({2'h0, cs_read_hold});
    end

    // Mismatched sums flagged; read strobe sum sets the cycle
    assign cfg_error = (cycle_len != cs_len);

    assign cycle_end = (cnt_reg + ebm_pkg::CNT_W'(1) >= cycle_len);

    // ------------------------------------------------------------
    // Area decode
    // ------------------------------------------------------------

    // Area from the latched transfer address
    always_comb
    begin
        area   = taddr_reg[ebm_pkg::AREA_MSB:ebm_pkg::AREA_LSB];
        in_cs3 = (area == ebm_pkg::AREA_CS3);
        in_cs4 = (area == ebm_pkg::AREA_CS4);
        in_cs5 = (area == ebm_pkg::AREA_CS5);
    end

    // ------------------------------------------------------------
    // Ownership arbitration
    // ------------------------------------------------------------

    // Static controller wins a tie; SDRAM keeps the bus until it drops sdr_req
    always_comb
    begin
        smc_take = smc_req;
        sdr_take = sdr_req && !smc_req;
    end

    // Owner state machine
    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            EBM_IDLE:
            begin
                if (smc_take)
                    state_next = EBM_SMC;
                else if (sdr_take)
                    state_next = EBM_SDR;
            end
            EBM_SMC:
            begin
                if (cycle_end)
                    state_next = (smc_float_cycles != '0) ? EBM_FLOAT : EBM_IDLE;
            end
            EBM_SDR:
            begin
                if (!sdr_req)
                    state_next = (sdr_float_cycles != '0) ? EBM_FLOAT : EBM_IDLE;
            end
            EBM_FLOAT:
            begin
                if (float_reg <= ebm_pkg::CNT_W'(1))
                    state_next = EBM_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            state_reg <= EBM_IDLE;
        else
            state_reg <= state_next;
    end

    // Float counter loaded from the controller that last drove
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            float_reg <= ebm_pkg::CNT_RST;
        else if (state_reg == EBM_SMC && cycle_end)
            float_reg <= ebm_pkg::CNT_W'({2'h0, smc_float_cycles});
        else if (state_reg == EBM_SDR && !sdr_req)
            float_reg <= ebm_pkg::CNT_W'({2'h0, sdr_float_cycles});
        else if (float_reg != ebm_pkg::CNT_RST)
            float_reg <= float_reg - ebm_pkg::CNT_W'(1);
    end

    // Cycle counter for static accesses
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            cnt_reg <= ebm_pkg::CNT_RST;
        else if (state_reg == EBM_SMC && !cycle_end)
            cnt_reg <= cnt_reg + ebm_pkg::CNT_W'(1);
        else
            cnt_reg <= ebm_pkg::CNT_RST;
    end

    // Transfer latched at the start of the cycle
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            taddr_reg <= '0;
            twr_reg   <= 1'b0;
        end
        else if (state_reg == EBM_IDLE && smc_take)
        begin
            taddr_reg <= smc_addr;
            twr_reg   <= smc_wr;
        end
    end

    // ------------------------------------------------------------
    // Strobe shaping
    // ------------------------------------------------------------

    // Read and chip-select timing links
    always_comb
    begin
        rd_ph.busy  = (state_reg == EBM_SMC);
        rd_ph.cnt   = cnt_reg;
        rd_ph.setup = read_strobe_setup;
        rd_ph.pulse = read_strobe_pulse;
        cs_ph.busy  = (state_reg == EBM_SMC);
        cs_ph.cnt   = cnt_reg;
        cs_ph.setup = cs_read_setup;
        cs_ph.pulse = cs_read_pulse;
        strobe_rd_n = rd_ph.strobe_n;
        strobe_cs_n = cs_ph.strobe_n;
    end

    ebm_phase u_rd_phase (
        .ph (rd_ph.gen)
    );

    ebm_phase u_cs_phase (
        .ph (cs_ph.gen)
    );

    // Command strobes, high outside an access
    always_comb
    begin
        read_strobe_n  = strobe_rd_n | twr_reg;
        write_strobe_n = strobe_rd_n | !twr_reg;
    end

    // One chip select per area, held high when idle
    always_comb
    begin
        chip_select_n = ebm_pkg::CS_N_RST;
        if (!strobe_cs_n && area >= ebm_pkg::AREA_CS0 && area <= ebm_pkg::AREA_CS7)
            chip_select_n[3'(area - ebm_pkg::AREA_CS0)] = 1'b0;
    end

    // Flash strobes gated by assignment and the live window
    always_comb
    begin
        flash_output_enable_n = !(cs3_flash_assign && in_cs3 && !chip_select_n[3]
                                  && !read_strobe_n);
        flash_write_enable_n  = !(cs3_flash_assign && in_cs3 && !chip_select_n[3]
                                  && !write_strobe_n);
    end

    // ------------------------------------------------------------
    // Card glue
    // ------------------------------------------------------------

    // Mode from address bits through the configurable table
    always_comb
    begin
        card_active = (state_reg == EBM_SMC)
                    && ((cs4_card_assign && in_cs4) || (cs5_card_assign && in_cs5));
        card_mode   = card_active
                    ? card_mode_map[2*taddr_reg[ebm_pkg::MODE_MSB:ebm_pkg::MODE_LSB] +: 2]
                    : 2'h0;
    end

    // ------------------------------------------------------------
    // Address pins
    // ------------------------------------------------------------

    // Lowest address bit driven depends on device width, mapped as the request is taken
    always_comb
    begin
        addr_map = smc_addr[ebm_pkg::ADDR_W-1:0];
        if (dev_width == ebm_pkg::WIDTH_16)
            addr_map[0] = 1'b0;
        else if (dev_width == ebm_pkg::WIDTH_32)
            addr_map[1:0] = 2'h0;
    end

    // Address and data pins change only when an owner drives them
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            mem_addr     <= '0;
            mem_data_out <= '0;
            mem_data_oe  <= 1'b0;
        end
        else if (state_reg == EBM_IDLE && smc_take)
        begin
            mem_addr     <= addr_map;
            mem_data_out <= smc_wdata;
            mem_data_oe  <= smc_wr;
        end
        else if (state_next == EBM_SDR)
        begin
            mem_addr     <= sdr_addr;
            mem_data_out <= sdr_wdata;
            mem_data_oe  <= sdr_drive;
        end
        else if (state_next != EBM_SMC)
            mem_data_oe  <= 1'b0;
    end

    // ------------------------------------------------------------
    // Read data and handshakes
    // ------------------------------------------------------------

    // Two-flop capture of the external data pins
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            din_meta_reg <= '0;
            din_sync_reg <= '0;
        end
        else
        begin
            din_meta_reg <= mem_data_in;
            din_sync_reg <= din_meta_reg;
        end
    end

    // Data sampled at the last cycle, acknowledge as a pulse
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            smc_ack   <= 1'b0;
            smc_rdata <= '0;
        end
        else
        begin
            smc_ack <= (state_reg == EBM_SMC) && cycle_end;
            if (state_reg == EBM_SMC && cycle_end && !twr_reg)
                smc_rdata <= din_sync_reg;
        end
    end

    assign sdr_grant = (state_reg == EBM_SDR);

    // ------------------------------------------------------------
    // Pull-up control
    // ------------------------------------------------------------

    // Low-half pull-ups on after reset, off when disabled; upper half untouched
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            pullup_low_en <= ebm_pkg::PULLUP_RST;
        else
            pullup_low_en <= !data_bus_pullup_disable;
    end

endmodule

// >>> test/ebm_top_props.sv
`timescale 1ns/10ps
module ebm_top_props (
    // Clock, reset and configuration
    input wire logic        clock,
    input wire logic        rst_n,
    input wire logic        data_bus_pullup_disable,
    input wire logic        cs3_flash_assign,
    input wire logic        cs4_card_assign,
    input wire logic [5:0]  sdr_float_cycles,
    input wire logic [15:0] card_mode_map,
    // Requests and answers
    input wire logic        smc_req,
    input wire logic        smc_ack,
    input wire logic        sdr_req,
    input wire logic        sdr_grant,
    // Pins
    input wire logic [25:0] mem_addr,
    input wire logic        mem_data_oe,
    input wire logic        read_strobe_n,
    input wire logic        write_strobe_n,
    input wire logic [7:0]  chip_select_n,
    input wire logic        flash_output_enable_n,
    input wire logic        flash_write_enable_n,
    input wire logic        card_active,
    input wire logic [1:0]  card_mode,
    input wire logic        pullup_low_en
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    // Nobody owns or asks for the bus
    sequence s_idle;
        !smc_req && !sdr_req && !sdr_grant;
    endsequence
    // Static answer comes in bounded time
    sequence s_ack;
        ##[1:300] smc_ack;
    endsequence
    // SDRAM hands back the bus with a float time set
    sequence s_handback;
        $fell(sdr_grant) && (sdr_float_cycles != 6'h00);
    endsequence
    chk_cs_onehot:
        assert property ($onehot0(~chip_select_n))
        else $error("two chip selects low");
    chk_idle_quiet:
        assert property (s_idle [*3] |-> $stable(mem_addr) && read_strobe_n && write_strobe_n)
        else $error("pins moved while idle");
    chk_pullup_bit:
        assert property ($past(rst_n) |-> pullup_low_en == !$past(data_bus_pullup_disable))
        else $error("pull-up enable wrong");
    chk_flash_read:
        assert property (!flash_output_enable_n |-> cs3_flash_assign && !chip_select_n[3]
            && !read_strobe_n)
        else $error("flash read strobe outside window");
    chk_flash_write:
        assert property (!flash_write_enable_n |-> cs3_flash_assign && !chip_select_n[3]
            && !write_strobe_n)
        else $error("flash write strobe outside window");
    chk_flash_route:
        assert property (cs3_flash_assign && !chip_select_n[3] |->
            flash_output_enable_n == read_strobe_n && flash_write_enable_n == write_strobe_n)
        else $error("flash strobes not following");
    chk_card_map:
        assert property (card_mode == (card_active ?
            card_mode_map[{mem_addr[23:21], 1'b0} +: 2] : 2'h0))
        else $error("card mode wrong");
    chk_card_glue:
        assert property (cs4_card_assign && !chip_select_n[4] |-> card_active)
        else $error("card glue inactive");
    chk_float_gap:
        assert property (s_handback |=> chip_select_n == 8'hff && !mem_data_oe)
        else $error("bus reused during float");
    chk_ack_bound:
        assert property ($rose(smc_req) |-> s_ack)
        else $error("static request not answered");
endmodule
bind ebm_top ebm_top_props i_ebm_top_props (.*);

// >>> test/ebm_mem_model.sv
`timescale 1ns/10ps
module ebm_mem_model (
    // Pins seen by the memory
    input  wire logic        clock,
    input  wire logic [25:0] mem_addr,
    input  wire logic [7:0]  chip_select_n,
    input  wire logic        mem_data_oe,
    // Data driven back
    output logic      [31:0] mem_data
);
    logic [31:0] last_reg = 32'h0;
    logic        sel;
    // Answers only while selected and the device is not driving
    assign sel = (chip_select_n != 8'hff) && !mem_data_oe;
    // Released bus shows the inverse of the last word, never a stale match
    always @(posedge clock)
        if (sel)
            last_reg <= mem_data;
    assign mem_data = sel ? {mem_addr[25:2], 8'h5a} : ~last_reg;
endmodule

// >>> test/tb_ebm_top.sv
`timescale 1ns/10ps
module tb_ebm_top;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic data_bus_pullup_disable, cs3_flash_assign, cs4_card_assign, cs5_card_assign;
    logic smc_req, smc_wr, sdr_req, sdr_drive, smc_ack, sdr_grant, mem_data_oe, cfg_error;
    logic read_strobe_n, write_strobe_n, flash_output_enable_n, flash_write_enable_n;
    logic card_active, pullup_low_en;
    logic [1:0] dev_width, card_mode;
    logic [5:0] read_strobe_setup, read_strobe_pulse, read_strobe_hold;
    logic [5:0] cs_read_setup, cs_read_pulse, cs_read_hold, smc_float_cycles, sdr_float_cycles;
    logic [15:0] card_mode_map;
    logic [31:0] smc_addr, smc_wdata, sdr_wdata, smc_rdata, mem_data_in, mem_data_out;
    logic [25:0] sdr_addr, mem_addr;
    logic [7:0] chip_select_n;
    int err_count = 0;
    int checked = 0;
    int cyc = 0;

    ebm_top i_ebm_top (.*);
    ebm_mem_model i_ebm_mem_model (.mem_data(mem_data_in), .*);

    // 25 MHz clock
    always #20 clock = ~clock;

    // Compare and report
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic summarize;
        if (err_count == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Hang guard
    always @(posedge clock)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            err_count++;
            summarize();
        end
    end

    // One static cycle, watched cycle by cycle from the take edge
    task automatic do_read(input logic [31:0] a, input logic [1:0] w, input logic wr,
                           input logic fl_on, input logic cd_on);
        int idx, first, st_cnt, cs_cnt, fl_cnt, cd_cnt, sh, len, done;
        logic [7:0] cs_seen;
        logic [25:0] ma;
        logic [1:0] md;
        idx = 0; first = 0; st_cnt = 0; cs_cnt = 0; fl_cnt = 0; cd_cnt = 0; done = 0;
        cs_seen = 8'h00; ma = '0; md = 2'h0;
        sh = (w == ebm_pkg::WIDTH_8) ? 0 : (w == ebm_pkg::WIDTH_16) ? 1 : 2;
        dev_width <= w;
        @(posedge clock);
        len = read_strobe_setup + read_strobe_pulse + read_strobe_hold;
        smc_wr <= wr; smc_addr <= a; smc_wdata <= ~a; smc_req <= 1'b1;
        while (!done && idx < 200)
        begin
            @(posedge clock);
            #1;
            idx++;
            if (idx == 1)
                ma = mem_addr;
            if (!(wr ? write_strobe_n : read_strobe_n))
            begin
                if (st_cnt == 0)
                    first = idx;
                st_cnt++;
            end
            if (chip_select_n != 8'hff)
                cs_cnt++;
            cs_seen = cs_seen | ~chip_select_n;
            if (!(wr ? flash_write_enable_n : flash_output_enable_n))
                fl_cnt++;
            if (card_active)
            begin
                cd_cnt++;
                md = card_mode;
            end
            if (smc_ack === 1'b1)
                done = 1;
        end
        check(idx, len + 1);
        check(first, read_strobe_setup + 1);
        check(st_cnt, read_strobe_pulse);
        check(cs_cnt, cs_read_pulse);
        check(cs_seen, 8'h01 << (a[31:28] - 4'h1));
        check(ma >> sh, a[25:0] >> sh);
        if (!wr)
            check(smc_rdata, {a[25:2], 8'h5a});
        check(fl_cnt, fl_on ? read_strobe_pulse : 0);
        check(cd_cnt > 0, cd_on);
        check(md, cd_on ? card_mode_map[{a[23:21], 1'b0} +: 2] : 2'h0);
        @(posedge clock);
        smc_req <= 1'b0;
    endtask

    // Pull-up disable bit
    task automatic t_pullup;
        @(posedge clock);
        data_bus_pullup_disable <= 1'b1;
        repeat (2) @(posedge clock);
        #1 check(pullup_low_en, 1'b0);
        @(posedge clock);
        data_bus_pullup_disable <= 1'b0;
        repeat (2) @(posedge clock);
        #1 check(pullup_low_en, 1'b1);
    endtask

    // Unequal strobe sums are flagged
    task automatic t_cfg;
        cs_read_hold <= 6'h01;
        @(posedge clock);
        #1 check(cfg_error, 1'b1);
        @(posedge clock);
        cs_read_hold <= 6'h00;
        @(posedge clock);
        #1 check(cfg_error, 1'b0);
    endtask

    // SDRAM owns the bus, static request waits out the float time
    task automatic t_sdram;
        int n, len;
        len = read_strobe_setup + read_strobe_pulse + read_strobe_hold;
        @(posedge clock);
        sdr_addr <= 26'h2a55a5; sdr_wdata <= 32'hc3c3_3c3c; sdr_drive <= 1'b1; sdr_req <= 1'b1;
        repeat (3) @(posedge clock);
        #1 check({sdr_grant, mem_data_oe, mem_addr}, {2'b11, 26'h2a55a5});
        check(mem_data_out, 32'hc3c3_3c3c);
        @(posedge clock);
        smc_addr <= 32'h1000_0040; smc_wr <= 1'b0; smc_req <= 1'b1;
        repeat (4) @(posedge clock);
        #1 check({smc_ack, chip_select_n}, {1'b0, 8'hff});
        @(posedge clock);
        sdr_req <= 1'b0;
        n = 0;
        while (smc_ack !== 1'b1 && n < 200)
        begin
            @(posedge clock);
            #1 n++;
        end
        check(n >= len + sdr_float_cycles + 1, 1'b1);
        check(smc_rdata, 32'h0000_105a);
        @(posedge clock);
        smc_req <= 1'b0;
    endtask

    initial
    begin
        {data_bus_pullup_disable, cs3_flash_assign, cs4_card_assign, cs5_card_assign} = 4'h0;
        {smc_req, smc_wr, sdr_req, sdr_drive} = 4'h0;
        dev_width = ebm_pkg::WIDTH_32;
        read_strobe_setup = 6'h02; read_strobe_pulse = 6'h04; read_strobe_hold = 6'h02;
        cs_read_setup = 6'h01; cs_read_pulse = 6'h07; cs_read_hold = 6'h00;
        smc_float_cycles = 6'h02; sdr_float_cycles = 6'h03; card_mode_map = 16'he4b1;
        smc_addr = '0; smc_wdata = '0; sdr_wdata = '0; sdr_addr = '0;
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        #1 check({pullup_low_en, read_strobe_n, chip_select_n, smc_ack, sdr_grant, mem_data_oe},
                 {2'b11, 8'hff, 3'b000});
        t_pullup();
        @(posedge clock);
        cs3_flash_assign <= 1'b1;
        cs4_card_assign <= 1'b1;
        do_read(32'h1000_0123, ebm_pkg::WIDTH_8, 1'b0, 1'b0, 1'b0);
        do_read(32'h1000_0456, ebm_pkg::WIDTH_16, 1'b0, 1'b0, 1'b0);
        do_read(32'h4000_0a5c, ebm_pkg::WIDTH_32, 1'b0, 1'b1, 1'b0);
        do_read(32'h4000_0a5c, ebm_pkg::WIDTH_32, 1'b1, 1'b1, 1'b0);
        do_read(32'h50a0_0010, ebm_pkg::WIDTH_16, 1'b0, 1'b0, 1'b1);
        do_read(32'h6040_0020, ebm_pkg::WIDTH_16, 1'b0, 1'b0, 1'b0);
        cs5_card_assign <= 1'b1;
        cs3_flash_assign <= 1'b0;
        do_read(32'h6040_0020, ebm_pkg::WIDTH_16, 1'b0, 1'b0, 1'b1);
        do_read(32'h4000_0a5c, ebm_pkg::WIDTH_32, 1'b0, 1'b0, 1'b0);
        read_strobe_setup <= 6'h01; read_strobe_pulse <= 6'h02; read_strobe_hold <= 6'h03;
        cs_read_setup <= 6'h00; cs_read_pulse <= 6'h06;
        do_read(32'h1000_0777, ebm_pkg::WIDTH_32, 1'b0, 1'b0, 1'b0);
        t_cfg();
        t_sdram();
        summarize();
    end
endmodule
